/* logic/ddri_ctrl.sv */
// DDR2 power-up initialisation controller with APB control
module ddri_ctrl #(
  parameter logic [15:0] STABLE_CYCLES = ddri_pkg::STABLE_DEF
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             mem_clk_en,
  output logic             mem_cke,
  output logic             mem_odt,
  output logic             mem_cs_n,
  output logic             mem_ras_n,
  output logic             mem_cas_n,
  output logic             mem_we_n,
  output logic      [2:0]  mem_ba,
  output logic      [15:0] mem_addr
);
  typedef enum logic [14:0] {
    S_IDLE   = 15'h0001,
    S_STABLE = 15'h0002,
    S_CKE    = 15'h0004,
    S_PRE1   = 15'h0008,
    S_EMR2   = 15'h0010,
    S_EMR3   = 15'h0020,
    S_DLLEN  = 15'h0040,
    S_DLLRST = 15'h0080,
    S_PRE2   = 15'h0100,
    S_REF    = 15'h0200,
    S_MRS    = 15'h0400,
    S_OCDDEF = 15'h0800,
    S_OCDEX  = 15'h1000,
    S_READY  = 15'h2000,
    S_GAP    = 15'h4000
  } ddri_state_e;

  ddri_state_e state_reg, ret_reg;
  logic [2:0]  ctrl;
  logic        start_pulse, act_pulse, rw_pulse;
  logic [15:0] mr_val, emr1_val, gap_val;
  logic [31:0] cmd_word, status;
  logic [1:0]  ref_reg;
  logic [7:0]  dll_cnt_reg;
  logic [7:0]  open_reg;
  logic        load;
  logic [15:0] load_val;
  logic        done;
  logic        err_reg;

  ddri_apb u_apb (
    .sys_clk     (sys_clk),
    .rst         (rst),
    .psel        (psel),
    .penable     (penable),
    .pwrite      (pwrite),
    .paddr       (paddr),
    .pwdata      (pwdata),
    .prdata      (prdata),
    .pready      (pready),
    .pslverr     (pslverr),
    .status      (status),
    .ctrl        (ctrl),
    .start_pulse (start_pulse),
    .mr_val      (mr_val),
    .emr1_val    (emr1_val),
    .gap_val     (gap_val),
    .act_pulse   (act_pulse),
    .rw_pulse    (rw_pulse),
    .cmd_word    (cmd_word)
  );

  ddri_timer u_timer (
    .sys_clk (sys_clk),
    .rst     (rst),
    .load    (load),
    .value   (load_val),
    .done    (done)
  );

  assign status = {16'h0000, open_reg, 5'h00, err_reg,
                   state_reg == S_READY, state_reg != S_IDLE};

  // Timer loads on entry to each wait
  always_comb begin
    load     = 1'b0;
    load_val = gap_val;
    case (state_reg)
      S_IDLE: begin
        load     = start_pulse && ctrl[ddri_pkg::CTRL_CLKON];
        load_val = STABLE_CYCLES;
      end
      S_STABLE: begin
        load     = done;
        load_val = ddri_pkg::CKE_CYC[15:0];
      end
      S_CKE, S_GAP, S_READY: load = 1'b0;
      S_OCDDEF: begin
        load = dll_cnt_reg == 8'h00;
      end
      default: load = 1'b1;
    endcase
  end

  // Count clocks since DLL enable; a slow gap value may cover it already
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dll_cnt_reg <= 8'h00;
    end else if (state_reg == S_DLLEN) begin
      dll_cnt_reg <= ddri_pkg::T_DLL_CLKS[7:0];
    end else if (dll_cnt_reg != 8'h00) begin
      dll_cnt_reg <= dll_cnt_reg - 8'h01;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_reg <= S_IDLE;
      ret_reg   <= S_IDLE;
      ref_reg   <= 2'h0;
    end else begin
      case (state_reg)
        S_IDLE: if (load) state_reg <= S_STABLE;
        S_STABLE: if (done) state_reg <= S_CKE;
        S_CKE: if (done) state_reg <= S_PRE1;
        S_PRE1: begin state_reg <= S_GAP; ret_reg <= S_EMR2; end
        S_EMR2: begin state_reg <= S_GAP; ret_reg <= S_EMR3; end
        S_EMR3: begin state_reg <= S_GAP; ret_reg <= S_DLLEN; end
        S_DLLEN: begin state_reg <= S_GAP; ret_reg <= S_DLLRST; end
        S_DLLRST: begin state_reg <= S_GAP; ret_reg <= S_PRE2; end
        S_PRE2: begin
          state_reg <= S_GAP;
          ret_reg   <= S_REF;
          ref_reg   <= 2'h0;
        end
        S_REF: begin
          state_reg <= S_GAP;
          ref_reg   <= ref_reg + 2'h1;
          ret_reg   <= (ref_reg + 2'h1 == ddri_pkg::REFRESH_CNT[1:0]) ?
                       S_MRS : S_REF;
        end
        S_MRS: begin
          state_reg <= S_GAP;
          ret_reg   <= ctrl[ddri_pkg::CTRL_OCDSK] ? S_OCDDEF : S_READY;
        end
        S_OCDDEF: if (load) begin
          state_reg <= S_GAP;
          ret_reg   <= S_OCDEX;
        end
        S_OCDEX: begin state_reg <= S_GAP; ret_reg <= S_READY; end
        S_GAP: if (done) state_reg <= ret_reg;
        S_READY: if (start_pulse) state_reg <= S_IDLE;
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // Clock and clock enable, termination always off
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mem_clk_en <= 1'b0;
      mem_cke    <= 1'b0;
      mem_odt    <= 1'b0;
    end else begin
      mem_clk_en <= ctrl[ddri_pkg::CTRL_CLKON];
      mem_cke    <= !(state_reg == S_IDLE || state_reg == S_STABLE);
      mem_odt    <= 1'b0;
    end
  end

  // Track open banks so reads and writes are only sent after activate
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      open_reg <= 8'h00;
      err_reg  <= 1'b0;
    end else if (state_reg != S_READY) begin
      open_reg <= 8'h00;
    end else if (act_pulse) begin
      open_reg[cmd_word[18:16]] <= 1'b1;
    end else if (rw_pulse) begin
      if (!open_reg[cmd_word[18:16]]) err_reg <= 1'b1;
      else if (cmd_word[ddri_pkg::A_PRE_ALL])
        open_reg[cmd_word[18:16]] <= 1'b0;
    end
  end

  // Command bus
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} <= ddri_pkg::CMD_DESEL;
      mem_ba   <= 3'h0;
      mem_addr <= 16'h0000;
    end else begin
      {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} <= ddri_pkg::CMD_NOP;
      mem_ba   <= 3'h0;
      mem_addr <= 16'h0000;
      case (state_reg)
        S_IDLE, S_STABLE: begin
          {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} <= ddri_pkg::CMD_DESEL;
        end
        S_PRE1, S_PRE2: begin
          {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} <= ddri_pkg::CMD_PRE;
          mem_addr[ddri_pkg::A_PRE_ALL] <= 1'b1;
        end
        S_EMR2: begin
          {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} <= ddri_pkg::CMD_MRS;
          mem_ba <= ddri_pkg::BANK_EM2;
        end
        S_EMR3: begin
          {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} <= ddri_pkg::CMD_MRS;
          mem_ba <= ddri_pkg::BANK_EM3;
        end
        S_DLLEN, S_OCDEX: begin
          {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} <= ddri_pkg::CMD_MRS;
          mem_ba   <= ddri_pkg::BANK_EM1;
          mem_addr <= emr1_val & ~ddri_pkg::EM1_OCD_MASK
                      & 16'h1FFE;
        end
        S_OCDDEF: if (load) begin
          {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} <= ddri_pkg::CMD_MRS;
          mem_ba   <= ddri_pkg::BANK_EM1;
          mem_addr <= (emr1_val | ddri_pkg::EM1_OCD_MASK) & 16'h1FFE;
        end
        S_DLLRST, S_MRS: begin
          {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} <= ddri_pkg::CMD_MRS;
          mem_ba   <= ddri_pkg::BANK_MR;
          mem_addr <= (mr_val & 16'h0F7F & ~(16'h0001 << ddri_pkg::A_DLL_RST))
                      | ((state_reg == S_DLLRST) ? 16'h0100 : 16'h0000);
        end
        S_REF: begin
          {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} <= ddri_pkg::CMD_REF;
        end
        S_READY: begin
          if (act_pulse) begin
            {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} <=
              ddri_pkg::CMD_ACT;
            mem_ba   <= cmd_word[18:16];
            mem_addr <= cmd_word[15:0];
          end else if (rw_pulse && open_reg[cmd_word[18:16]]) begin
            // Bit 20 selects write; column burst order is set by MR
            {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} <=
              cmd_word[20] ? ddri_pkg::CMD_WR : ddri_pkg::CMD_RD;
            mem_ba   <= cmd_word[18:16];
            mem_addr <= cmd_word[15:0];
          end
        end
        default: ;
      endcase
    end
  end

  cke_low_a: assert property (@(posedge sys_clk) disable iff (rst)
    state_reg == S_STABLE |=> !mem_cke)
    else $error("cke high during power-up wait");
  odt_low_a: assert property (@(posedge sys_clk) disable iff (rst)
    ##1 !mem_odt)
    else $error("odt driven high");
  cke_nop_a: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(mem_cke) |-> {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n}
      == ddri_pkg::CMD_NOP [*8])
    else $error("command during cke settle time");
  emr2_bank_a: assert property (@(posedge sys_clk) disable iff (rst)
    state_reg == S_EMR2 |=> mem_ba == 3'h2 && !mem_ras_n && !mem_we_n)
    else $error("emr2 bank wrong");
  emr3_bank_a: assert property (@(posedge sys_clk) disable iff (rst)
    state_reg == S_EMR3 |=> mem_ba == 3'h3 && !mem_cas_n)
    else $error("emr3 bank wrong");
  dll_en_a: assert property (@(posedge sys_clk) disable iff (rst)
    state_reg == S_DLLEN |=> mem_addr[9:7] == 3'h0 && !mem_addr[0])
    else $error("dll enable bits wrong");
  dll_rst_a: assert property (@(posedge sys_clk) disable iff (rst)
    state_reg == S_DLLRST |=> mem_addr[8] && mem_ba == 3'h0)
    else $error("dll reset bit missing");
  mrs_final_a: assert property (@(posedge sys_clk) disable iff (rst)
    state_reg == S_MRS |=> !mem_addr[8] && !mem_addr[7])
    else $error("final mode write wrong");
  // Counted apart from the pacing counter so the check does not echo it
  logic [7:0] since_dll_reg;
  logic [3:0] cmd_bus;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      since_dll_reg <= 8'h00;
    end else if (state_reg == S_DLLEN) begin
      since_dll_reg <= 8'h00;
    end else if (since_dll_reg != 8'hFF) begin
      since_dll_reg <= since_dll_reg + 8'h01;
    end
  end

  assign cmd_bus = {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n};

  ocd_wait_a: assert property (@(posedge sys_clk) disable iff (rst)
    cmd_bus == ddri_pkg::CMD_MRS && mem_ba == ddri_pkg::BANK_EM1
      && mem_addr[9:7] == 3'h7
    |-> since_dll_reg >= ddri_pkg::T_DLL_CLKS[7:0])
    else $error("ocd default too early");
  cke_idle_a: assert property (@(posedge sys_clk) disable iff (rst)
    state_reg == S_IDLE |=> !mem_cke)
    else $error("cke high before start");
  clk_first_a: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(mem_cke) |-> mem_clk_en)
    else $error("cke raised without clock");
  pre_all_a: assert property (@(posedge sys_clk) disable iff (rst)
    state_reg == S_PRE1 || state_reg == S_PRE2
    |=> cmd_bus == ddri_pkg::CMD_PRE && mem_addr[ddri_pkg::A_PRE_ALL])
    else $error("precharge all wrong");
  ref_cmd_a: assert property (@(posedge sys_clk) disable iff (rst)
    state_reg == S_REF |=> cmd_bus == ddri_pkg::CMD_REF)
    else $error("refresh missing");
  mr_final_bank_a: assert property (@(posedge sys_clk) disable iff (rst)
    state_reg == S_MRS |=> cmd_bus == ddri_pkg::CMD_MRS
      && mem_ba == ddri_pkg::BANK_MR)
    else $error("final mode write not to mode register");
  ocd_exit_a: assert property (@(posedge sys_clk) disable iff (rst)
    state_reg == S_OCDEX |=> mem_ba == ddri_pkg::BANK_EM1
      && mem_addr[9:7] == 3'h0)
    else $error("ocd exit bits wrong");
  mrs_idle_a: assert property (@(posedge sys_clk) disable iff (rst)
    cmd_bus == ddri_pkg::CMD_MRS |-> mem_cke && open_reg == 8'h00)
    else $error("mode write with open bank or cke low");
  gap_nop_a: assert property (@(posedge sys_clk) disable iff (rst)
    state_reg == S_GAP |=> cmd_bus == ddri_pkg::CMD_NOP)
    else $error("command inside init gap");
  rw_closed_a: assert property (@(posedge sys_clk) disable iff (rst)
    state_reg == S_READY && rw_pulse && !open_reg[cmd_word[18:16]]
    |=> cmd_bus == ddri_pkg::CMD_NOP)
    else $error("access sent to closed bank");
endmodule : ddri_ctrl

/* logic/ddri_pkg.sv */
// Package of constants for the DDR2 power-up initialisation controller
package ddri_pkg;
  localparam int unsigned CLK_MHZ      = 250;
  localparam int unsigned T_STABLE_US  = 200;
  localparam int unsigned T_CKE_NS     = 400;
  localparam int unsigned T_DLL_CLKS   = 200;
  localparam int unsigned STABLE_CYC   = T_STABLE_US * CLK_MHZ;
  localparam int unsigned CKE_CYC      = (T_CKE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned REFRESH_CNT  = 2;
  localparam int unsigned CNT_W        = 16;
  localparam int unsigned GAP_DEF      = 32;
  localparam logic [15:0] STABLE_DEF   = 16'hC350;

  localparam int unsigned ADDR_W = 16;
  localparam int unsigned BANK_W = 3;

  // Command code on cs_n, ras_n, cas_n, we_n
  localparam logic [3:0] CMD_NOP   = 4'h7;
  localparam logic [3:0] CMD_PRE   = 4'h2;
  localparam logic [3:0] CMD_REF   = 4'h1;
  localparam logic [3:0] CMD_MRS   = 4'h0;
  localparam logic [3:0] CMD_DESEL = 4'h8;
  localparam logic [3:0] CMD_ACT   = 4'h3;
  localparam logic [3:0] CMD_WR    = 4'h4;
  localparam logic [3:0] CMD_RD    = 4'h5;

  localparam logic [2:0] BANK_MR  = 3'h0;
  localparam logic [2:0] BANK_EM1 = 3'h1;
  localparam logic [2:0] BANK_EM2 = 3'h2;
  localparam logic [2:0] BANK_EM3 = 3'h3;

  localparam int unsigned A_PRE_ALL  = 10;
  localparam int unsigned A_DLL_RST  = 8;
  localparam int unsigned A_TEST     = 7;
  localparam int unsigned A_DLL_DIS  = 0;
  localparam logic [15:0] EM1_OCD_MASK = 16'h0380;

  // Register offsets on APB
  localparam logic [11:0] REG_CTRL   = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_MR     = 12'h008;
  localparam logic [11:0] REG_EMR1   = 12'h00C;
  localparam logic [11:0] REG_GAP    = 12'h010;
  localparam logic [11:0] REG_ACT    = 12'h014;
  localparam logic [11:0] REG_RW     = 12'h018;

  localparam int unsigned CTRL_START = 0;
  localparam int unsigned CTRL_CLKON = 1;
  localparam int unsigned CTRL_OCDSK = 2;
endpackage : ddri_pkg

/* logic/ddri_timer.sv */
// Down-counter that paces waits between initialisation steps
module ddri_timer (
  input  wire logic                    sys_clk,
  input  wire logic                    rst,
  input  wire logic                    load,
  input  wire logic [ddri_pkg::CNT_W-1:0] value,
  output logic                         done
);
  logic [ddri_pkg::CNT_W-1:0] cnt_reg;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
    end else if (load) begin
      cnt_reg <= value;
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end

  // Done must not look at load: the caller derives load from done
  assign done = (cnt_reg == '0);
endmodule : ddri_timer

/* logic/ddri_apb.sv */
// APB slave register file for the initialisation controller
module ddri_apb (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [31:0] status,
  output logic      [2:0]  ctrl,
  output logic             start_pulse,
  output logic      [15:0] mr_val,
  output logic      [15:0] emr1_val,
  output logic      [15:0] gap_val,
  output logic             act_pulse,
  output logic             rw_pulse,
  output logic      [31:0] cmd_word
);
  logic wr_en;
  logic known;

  assign wr_en = psel && penable && pwrite;
  assign pready = 1'b1;

  always_comb begin
    known = 1'b1;
    prdata = 32'h0000_0000;
    case (paddr)
      ddri_pkg::REG_CTRL:   prdata = {29'h0, ctrl};
      ddri_pkg::REG_STATUS: prdata = status;
      ddri_pkg::REG_MR:     prdata = {16'h0000, mr_val};
      ddri_pkg::REG_EMR1:   prdata = {16'h0000, emr1_val};
      ddri_pkg::REG_GAP:    prdata = {16'h0000, gap_val};
      ddri_pkg::REG_ACT:    prdata = cmd_word;
      ddri_pkg::REG_RW:     prdata = cmd_word;
      default:              known = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !known;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl        <= 3'h0;
      mr_val      <= 16'h0000;
      emr1_val    <= 16'h0000;
      gap_val     <= ddri_pkg::GAP_DEF[15:0];
      start_pulse <= 1'b0;
      act_pulse   <= 1'b0;
      rw_pulse    <= 1'b0;
      cmd_word    <= 32'h0000_0000;
    end else begin
      start_pulse <= 1'b0;
      act_pulse   <= 1'b0;
      rw_pulse    <= 1'b0;
      if (wr_en) begin
        case (paddr)
          ddri_pkg::REG_CTRL: begin
            ctrl        <= pwdata[2:0];
            start_pulse <= pwdata[ddri_pkg::CTRL_START];
          end
          ddri_pkg::REG_MR:   mr_val   <= pwdata[15:0];
          ddri_pkg::REG_EMR1: emr1_val <= pwdata[15:0];
          ddri_pkg::REG_GAP:  gap_val  <= pwdata[15:0];
          ddri_pkg::REG_ACT: begin
            cmd_word  <= pwdata;
            act_pulse <= 1'b1;
          end
          ddri_pkg::REG_RW: begin
            cmd_word <= pwdata;
            rw_pulse <= 1'b1;
          end
          default: ;
        endcase
      end
    end
  end
endmodule : ddri_apb

/* tb/ddri_mem_model.sv */
// Behavioural DDR2 device that checks the power-up command stream
module ddri_mem_model #(
  parameter int unsigned STABLE  = 20,
  parameter int unsigned MIN_GAP = 4
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        mem_clk_en,
  input  wire logic        mem_cke,
  input  wire logic        mem_odt,
  input  wire logic        mem_cs_n,
  input  wire logic        mem_ras_n,
  input  wire logic        mem_cas_n,
  input  wire logic        mem_we_n,
  input  wire logic [2:0]  mem_ba,
  input  wire logic [15:0] mem_addr,
  output logic      [7:0]  err_cnt,
  output logic      [7:0]  cmd_cnt,
  output logic      [3:0]  step,
  output logic      [7:0]  open_banks,
  output logic      [15:0] last_addr,
  output logic      [15:0] last_gap,
  output logic      [15:0] emr1_seen,
  output logic      [15:0] mr_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0]  cmd;
  logic        idle, cke_q, mrs, ok;
  logic [15:0] keep;
  int unsigned st_cnt, nop_run, dll_cnt, e;
  assign cmd  = {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n};
  assign idle = mem_cs_n || (cmd == ddri_pkg::CMD_NOP);
  assign mrs  = (cmd == ddri_pkg::CMD_MRS);
  // OCD writes must keep every other setting of the DLL-enable write
  assign keep = (mem_addr ^ emr1_seen) & ~ddri_pkg::EM1_OCD_MASK;
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      {err_cnt, cmd_cnt, step, open_banks, cke_q} <= '0;
      {last_addr, last_gap, emr1_seen, mr_seen} <= '0;
      st_cnt <= 0;
      nop_run <= 0;
      dll_cnt <= 0;
    end else begin
      e = 0;
      ok = 1'b1;
      cke_q <= mem_cke;
      dll_cnt <= dll_cnt + 1;
      if (mem_odt) e++;
      if (mem_cke && !mem_clk_en) e++;
      if (!mem_cke && !idle) e++;
      if (mem_clk_en && !mem_cke) st_cnt <= st_cnt + 1;
      if (mem_cke && !cke_q && st_cnt < STABLE) e++;
      if (mem_cke && !cke_q) nop_run <= 1;
      else if (idle) nop_run <= nop_run + 1;
      if (mem_cke && cke_q && !idle) begin
        nop_run <= 0;
        last_gap <= 16'(nop_run);
        cmd_cnt <= cmd_cnt + 1;
        last_addr <= mem_addr;
        if (step != 0 && nop_run < MIN_GAP) e++;
        if (mrs && open_banks != 0) e++;
        case (step)
          4'd0: ok = cmd == ddri_pkg::CMD_PRE && mem_addr[10]
                     && nop_run >= ddri_pkg::CKE_CYC;
          4'd1: ok = mrs && mem_ba == ddri_pkg::BANK_EM2;
          4'd2: ok = mrs && mem_ba == ddri_pkg::BANK_EM3;
          4'd3: ok = mrs && mem_ba == ddri_pkg::BANK_EM1
                     && (mem_addr & 16'hE381) == 16'h0000;
          4'd4: ok = mrs && mem_ba == ddri_pkg::BANK_MR && mem_addr[8]
                     && mem_addr[15:13] == 3'h0;
          4'd5: ok = cmd == ddri_pkg::CMD_PRE && mem_addr[10];
          4'd6, 4'd7: ok = cmd == ddri_pkg::CMD_REF;
          4'd8: ok = mrs && mem_ba == ddri_pkg::BANK_MR
                     && mem_addr[8:7] == 2'b00
                     && mem_addr[2:1] == 2'b01;
          4'd10: ok = mrs && mem_ba == ddri_pkg::BANK_EM1
                      && mem_addr[9:7] == 3'h0 && keep == 0;
          default: ok = 1'b1;
        endcase
        if (step == 4'd3) begin
          emr1_seen <= mem_addr;
          dll_cnt <= 0;
        end
        if (step == 4'd8) mr_seen <= mem_addr;
        if (step < 4'd9) step <= step + 1;
        else if (mrs && step == 4'd9) begin
          ok = mem_ba == ddri_pkg::BANK_EM1 && mem_addr[9:7] == 3'h7
               && keep == 0 && dll_cnt + 1 >= ddri_pkg::T_DLL_CLKS;
          step <= 4'd10;
        end else if (step == 4'd10) step <= 4'd11;
        else begin
          // Activate, then read or write only to an open bank
          if (cmd == 4'h3) begin
            ok = !open_banks[mem_ba];
            open_banks[mem_ba] <= 1'b1;
          end else if (cmd == 4'h4 || cmd == 4'h5) begin
            ok = open_banks[mem_ba];
            if (mem_addr[10]) open_banks[mem_ba] <= 1'b0;
          end else ok = 1'b0;
        end
      end
      err_cnt <= err_cnt + 8'(e) + (ok ? 8'd0 : 8'd1);
    end
  end
endmodule : ddri_mem_model

/* tb/sdram_power_up_init_sequence_bench.sv */
// Self-checking bench for the DDR2 power-up initialisation controller
module sdram_power_up_init_sequence_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        mem_clk_en, mem_cke, mem_odt, mem_cs_n, mem_ras_n;
  logic        mem_cas_n, mem_we_n, serr, berr;
  logic [2:0]  mem_ba;
  logic [15:0] mem_addr, last_addr, last_gap, emr1_seen, mr_seen;
  logic [15:0] mr, emr1, gap;
  logic [7:0]  err_cnt, cmd_cnt, open_banks, banks;
  logic [3:0]  step;
  int          fail_count, compares, cycles;
  ddri_ctrl #(.STABLE_CYCLES(16'h0014)) dut (
    .sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .mem_clk_en, .mem_cke, .mem_odt, .mem_cs_n,
    .mem_ras_n, .mem_cas_n, .mem_we_n, .mem_ba, .mem_addr
  );
  ddri_mem_model #(.STABLE(20), .MIN_GAP(4)) mem (
    .sys_clk, .rst, .mem_clk_en, .mem_cke, .mem_odt, .mem_cs_n, .mem_ras_n,
    .mem_cas_n, .mem_we_n, .mem_ba, .mem_addr, .err_cnt, .cmd_cnt, .step,
    .open_banks, .last_addr, .last_gap, .emr1_seen, .mr_seen
  );
  function automatic logic [31:0] exp_step(input logic ocd);
    return ocd ? 32'h0000_000B : 32'h0000_0009;
  endfunction : exp_step
  // DLL on, OCD bits cleared, reserved top bits cleared
  function automatic logic [31:0] exp_emr1(input logic [15:0] v);
    return {16'h0000, v & 16'h1C7E};
  endfunction : exp_emr1
  task automatic summarize();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize
  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s seen %h want %h", $time, what, seen,
               exp);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_cmd(input logic [7:0] prev);
    for (int n = 0; n < 20 && cmd_cnt === prev; n++) @(posedge sys_clk);
    check(32'(cmd_cnt), 32'(prev) + 1, "one command");
  endtask : wait_cmd
  task automatic run_init(input logic ocd);
    int n;
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    check({28'h0, mem_cke, mem_odt, mem_cs_n, mem_clk_en}, 32'h2,
          "reset pins");
    rst <= 1'b0;
    banks = '0;
    berr = 1'b0;
    mr = {4'h0, 3'($urandom), 2'b00, 3'($urandom), 1'($urandom),
          3'($urandom_range(3, 2))};
    emr1 = 16'($urandom);
    gap = 16'($urandom_range(9, 3));
    apb(1'b1, ddri_pkg::REG_MR, {16'h0000, mr});
    apb(1'b1, ddri_pkg::REG_EMR1, {16'h0000, emr1});
    apb(1'b1, ddri_pkg::REG_GAP, {16'h0000, gap});
    // Clock first so the stable wait is counted on a running clock
    apb(1'b1, ddri_pkg::REG_CTRL, 32'h0000_0002);
    apb(1'b1, ddri_pkg::REG_CTRL, {29'h0, ocd, 2'b11});
    n = 0;
    do begin
      apb(1'b0, ddri_pkg::REG_STATUS, 32'h0000_0000);
      n++;
    end while (rd[1] !== 1'b1 && n < 600);
    // Busy stays set while ready: it only reads low in the idle state
    check(rd[1:0], 32'h3, "ready");
    check(32'(err_cnt), 0, "init stream");
    check(32'(step), exp_step(ocd), "init steps");
    check(32'(emr1_seen), exp_emr1(emr1), "dll enable");
    check(32'(mr_seen), 32'(mr), "mode");
    check(32'(last_gap), 32'(gap) + 1, "gap");
  endtask : run_init
  task automatic normal_ops();
    logic [2:0]  b;
    logic [15:0] v;
    logic [7:0]  prev;
    for (int i = 0; i < 10; i++) begin
      b = 3'($urandom);
      v = 16'($urandom);
      prev = cmd_cnt;
      if (banks[b] !== 1'b1) begin
        apb(1'b1, ddri_pkg::REG_ACT, {13'h0, b, v});
        wait_cmd(prev);
        banks[b] = 1'b1;
        check(32'(last_addr), 32'(v), "row");
        check(32'(open_banks), 32'(banks), "act bank");
      end
      b = 3'($urandom);
      v = (i == 0) ? 16'hFFFF : 16'($urandom);
      prev = cmd_cnt;
      apb(1'b1, ddri_pkg::REG_RW, {11'h0, 1'($urandom), 1'b0, b, v});
      if (banks[b] === 1'b1) begin
        wait_cmd(prev);
        check(32'(last_addr), 32'(v), "column");
        if (v[10]) banks[b] = 1'b0;
      end else begin
        // A closed bank must produce no command at all
        repeat (10) @(posedge sys_clk);
        check(32'(cmd_cnt), 32'(prev), "refused");
        berr = 1'b1;
      end
      apb(1'b0, ddri_pkg::REG_STATUS, 32'h0000_0000);
      check({rd[15:8], rd[2]}, {23'h0, banks, berr}, "banks");
    end
    check(32'(err_cnt), 0, "normal stream");
  endtask : normal_ops
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      summarize();
    end
  end
  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata} = '0;
    rst = 1'b1;
    void'($urandom(32'h91f9_6cde));
    run_init(1'b1);
    normal_ops();
    apb(1'b0, 12'h0FC, 32'h0000_0000);
    check({31'h0, serr}, 32'h1, "unmapped error");
    check(rd, 32'h0, "unmapped data");
    run_init(1'b0);
    normal_ops();
    summarize();
  end
endmodule : sdram_power_up_init_sequence_bench
